// ### hw/srs_pkg.sv
// package for the shift/rotate/swap unit
// assumes an 8-bit datapath and a one-hot-free opcode from the decoder
package srs_pkg;
	localparam int SRS_DATA_W = 8;
	localparam logic [7:0] SRS_ACC_RST = 8'h00;
	localparam logic SRS_FLAG_RST = 1'b0;
	localparam int SRS_MSB_POS = 7;
	localparam int SRS_LSB_POS = 0;
	localparam int SRS_NIB_W = 4;

	typedef enum logic [3:0] {
		SRS_OP_NONE,
		SRS_OP_SHR_ACC,
		SRS_OP_RRC_ACC,
		SRS_OP_SHR_MEM,
		SRS_OP_RRC_MEM,
		SRS_OP_SHL_ACC,
		SRS_OP_RLC_ACC,
		SRS_OP_SHL_MEM,
		SRS_OP_RLC_MEM,
		SRS_OP_SWAP_ACC
	} srs_op_t;

	typedef struct packed {
		logic zero_flag;
		logic carry_flag;
		logic auxiliary_carry_flag;
		logic overflow_flag;
	} srs_flags_t;

	typedef struct packed {
		logic       wr_en;
		logic [7:0] addr;
		logic [7:0] data;
	} srs_mem_wr_t;
endpackage

// ### hw/srs_shifter.sv
// combinational one-place shifter with a carry in and carry out
// assumes the caller picks direction and fill; no state here
`timescale 1ns/1ps
module srs_shifter #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] val_in,
	input  wire logic         left_in,
	input  wire logic         fill_in,
	output logic      [W-1:0] res_out,
	output logic              cout_out
);
	initial begin
		if (W < 2) $error("srs_shifter needs W >= 2");
	end
	always_comb begin
		if (left_in) begin
			res_out  = {val_in[W-2:0], fill_in};
			cout_out = val_in[W-1];
		end else begin
			res_out  = {fill_in, val_in[W-1:1]};
			cout_out = val_in[0];
		end
	end
endmodule

// ### hw/srs_unit.sv
// shift, rotate and nibble swap unit of an 8-bit core datapath
// assumes the decoder holds op and address stable while op_valid is high,
// and data memory returns read data one cycle after the read strobe
`timescale 1ns/1ps
module srs_unit
	import srs_pkg::*;
#(
	parameter int DATA_W = SRS_DATA_W
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_n_in,
	input  wire logic                    clk_en_in,
	input  wire srs_pkg::srs_op_t        op_in,
	input  wire logic                    op_valid_in,
	input  wire logic [7:0]              mem_addr_in,
	input  wire logic [DATA_W-1:0]       mem_rd_data_in,
	input  wire logic                    acc_load_in,
	input  wire logic [DATA_W-1:0]       acc_load_data_in,
	input  wire logic                    flags_load_in,
	input  wire srs_pkg::srs_flags_t     flags_load_data_in,
	output logic                         op_ready_out,
	output logic                         op_done_out,
	output logic                         mem_rd_en_out,
	output logic [7:0]                   mem_rd_addr_out,
	output srs_pkg::srs_mem_wr_t         mem_wr_out,
	output logic [DATA_W-1:0]            accumulator_out,
	output srs_pkg::srs_flags_t          flags_out
);
	import srs_pkg::*;

	initial begin
		if (DATA_W != SRS_DATA_W) $error("srs_unit supports 8-bit data only");
	end

	typedef enum logic [1:0] {
		SRS_ST_IDLE,
		SRS_ST_READ,
		SRS_ST_WRITE
	} srs_state_t;

	function automatic logic op_is_mem(input srs_op_t op);
		op_is_mem = (op == SRS_OP_SHR_MEM) || (op == SRS_OP_RRC_MEM) ||
			(op == SRS_OP_SHL_MEM) || (op == SRS_OP_RLC_MEM);
	endfunction

	function automatic logic op_is_left(input srs_op_t op);
		op_is_left = (op == SRS_OP_SHL_ACC) || (op == SRS_OP_RLC_ACC) ||
			(op == SRS_OP_SHL_MEM) || (op == SRS_OP_RLC_MEM);
	endfunction

	function automatic logic op_is_rot(input srs_op_t op);
		op_is_rot = (op == SRS_OP_RRC_ACC) || (op == SRS_OP_RLC_ACC) ||
			(op == SRS_OP_RRC_MEM) || (op == SRS_OP_RLC_MEM);
	endfunction

	function automatic logic op_is_shift(input srs_op_t op);
		op_is_shift = (op != SRS_OP_NONE) && (op != SRS_OP_SWAP_ACC);
	endfunction

	srs_state_t          state_r;
	srs_state_t          state_nxt;
	logic [DATA_W-1:0]   acc_r;
	logic [DATA_W-1:0]   acc_nxt;
	srs_flags_t          flags_r;
	srs_flags_t          flags_nxt;
	srs_mem_wr_t         wr_r;
	srs_mem_wr_t         wr_nxt;
	logic                done_r;
	logic                done_nxt;
	logic [7:0]          addr_r;
	logic [7:0]          addr_nxt;
	srs_op_t             op_r;
	srs_op_t             op_nxt;

	logic [DATA_W-1:0]   sh_src;
	logic [DATA_W-1:0]   sh_res;
	logic                sh_cout;
	logic                sh_fill;
	logic                sh_left;
	srs_op_t             cur_op;

	// memory ops use the latched opcode; accumulator ops use the live one
	assign cur_op  = (state_r == SRS_ST_READ) ? op_r : op_in;
	assign sh_left = op_is_left(cur_op);
	// rotates pull the old carry in, plain shifts pull zero
	assign sh_fill = op_is_rot(cur_op) & flags_r.carry_flag;
	assign sh_src  = (state_r == SRS_ST_READ) ? mem_rd_data_in : acc_r;

	srs_shifter #(
		.W (DATA_W)
	) u_shifter (
		.val_in   (sh_src),
		.left_in  (sh_left),
		.fill_in  (sh_fill),
		.res_out  (sh_res),
		.cout_out (sh_cout)
	);

	always_comb begin
		state_nxt = state_r;
		acc_nxt   = acc_r;
		flags_nxt = flags_r;
		wr_nxt    = '0;
		done_nxt  = 1'b0;
		addr_nxt  = addr_r;
		op_nxt    = op_r;
		case (state_r)
			SRS_ST_IDLE: begin
				if (op_valid_in && op_is_mem(op_in)) begin
					// three-cycle form: read now, shift next cycle, write strobe out the cycle after
					addr_nxt  = mem_addr_in;
					op_nxt    = op_in;
					state_nxt = SRS_ST_READ;
				end else if (op_valid_in && op_in == SRS_OP_SWAP_ACC) begin
					// no flag touched by swap
					acc_nxt = {acc_r[SRS_NIB_W-1:0],
						acc_r[DATA_W-1:SRS_NIB_W]};
					done_nxt = 1'b1;
				end else if (op_valid_in && op_is_shift(op_in)) begin
					acc_nxt = sh_res;
					// only carry moves; zero flag kept even on zero result
					flags_nxt.carry_flag = sh_cout;
					done_nxt = 1'b1;
				end else begin
					// direct loads from the rest of the core when no op runs
					if (acc_load_in) begin
						acc_nxt = acc_load_data_in;
					end
					if (flags_load_in) begin
						flags_nxt = flags_load_data_in;
					end
				end
			end
			SRS_ST_READ: begin
				wr_nxt.wr_en = 1'b1;
				wr_nxt.addr  = addr_r;
				wr_nxt.data  = sh_res;
				flags_nxt.carry_flag = sh_cout;
				state_nxt = SRS_ST_WRITE;
			end
			SRS_ST_WRITE: begin
				done_nxt  = 1'b1;
				state_nxt = SRS_ST_IDLE;
			end
			default: begin
				state_nxt = SRS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_r <= SRS_ST_IDLE;
			acc_r   <= SRS_ACC_RST;
			flags_r <= {4{SRS_FLAG_RST}};
			wr_r    <= '0;
			done_r  <= 1'b0;
			addr_r  <= 8'h00;
			op_r    <= SRS_OP_NONE;
		end else if (clk_en_in) begin
			state_r <= state_nxt;
			acc_r   <= acc_nxt;
			flags_r <= flags_nxt;
			wr_r    <= wr_nxt;
			done_r  <= done_nxt;
			addr_r  <= addr_nxt;
			op_r    <= op_nxt;
		end
	end

	// read strobe combinational so data is back by the next edge
	assign mem_rd_en_out   = (state_r == SRS_ST_IDLE) && op_valid_in &&
		op_is_mem(op_in);
	assign mem_rd_addr_out = mem_addr_in;
	assign op_ready_out    = (state_r == SRS_ST_IDLE);
	assign op_done_out     = done_r;
	assign mem_wr_out      = wr_r;
	assign accumulator_out = acc_r;
	assign flags_out       = flags_r;
endmodule

// ### dv/srs_mem_model.sv
// data memory stand-in for srs_unit
// assumes read data is due one cycle after the read strobe
`timescale 1ns/1ps
module srs_mem_model import srs_pkg::*; (
	input  wire logic        clk_in,
	input  wire logic        rd_en_in,
	input  wire logic [7:0]  rd_addr_in,
	input  wire srs_mem_wr_t wr_in,
	output logic      [7:0]  rd_data_out
);
	logic [7:0] mem [256];
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37);
		rd_data_out = 8'h00;
	end
	// idle bus toggles so stale data never passes for valid
	always @(posedge clk_in) begin
		rd_data_out <= rd_en_in ? mem[rd_addr_in] : ~rd_data_out;
		if (wr_in.wr_en) mem[wr_in.addr] <= wr_in.data;
	end
endmodule

// ### dv/srs_unit_sva.sv
// assertions for srs_unit
// assumes binding to the srs_unit ports
`timescale 1ns/1ps
module srs_unit_sva import srs_pkg::*; (
	input wire logic        clk_in, rst_n_in, clk_en_in, flags_load_in,
	input wire logic        op_valid_in, op_ready_out,
	input wire srs_op_t     op_in,
	input wire logic [7:0]  mem_addr_in, mem_rd_data_in, accumulator_out,
	input wire srs_flags_t  flags_out,
	input wire srs_mem_wr_t mem_wr_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire tk = op_valid_in && op_ready_out && clk_en_in;
	wire [7:0] a = accumulator_out;
	wire [7:0] d = mem_rd_data_in;
	wire c = flags_out.carry_flag;
	wire [2:0] o = {flags_out.zero_flag, flags_out.auxiliary_carry_flag,
		flags_out.overflow_flag};
	property p_shr;
		tk && op_in == SRS_OP_SHR_ACC |=> a == $past(a) >> 1 && c == $past(a[0]);
	endproperty
	a_shr: assert property (p_shr) else $error("shift right wrong");
	property p_rrc;
		tk && op_in == SRS_OP_RRC_ACC |=> a == {$past(c), $past(a[7:1])};
	endproperty
	a_rrc: assert property (p_rrc) else $error("rotate right wrong");
	property p_shl;
		tk && op_in == SRS_OP_SHL_ACC |=> a == $past(a) << 1 && c == $past(a[7]);
	endproperty
	a_shl: assert property (p_shl) else $error("shift left wrong");
	property p_rlc;
		tk && op_in == SRS_OP_RLC_ACC |=> a == {$past(a[6:0]), $past(c)};
	endproperty
	a_rlc: assert property (p_rlc) else $error("rotate left wrong");
	property p_swap;
		tk && op_in == SRS_OP_SWAP_ACC |=> $stable(flags_out) &&
			a == {$past(a[3:0]), $past(a[7:4])};
	endproperty
	a_swap: assert property (p_swap) else $error("swap wrong");
	property p_keep;
		$changed(o) |-> $past(flags_load_in);
	endproperty
	a_keep: assert property (p_keep) else $error("flag moved");
	property p_shr_mem;
		tk && op_in == SRS_OP_SHR_MEM |=> ##1 c == $past(d[0]) &&
			mem_wr_out == {1'b1, $past(mem_addr_in, 2), $past(d) >> 1};
	endproperty
	a_shr_mem: assert property (p_shr_mem) else $error("mem shr wrong");
	property p_rlc_mem;
		tk && op_in == SRS_OP_RLC_MEM |=> ##1 c == $past(d[7]) && mem_wr_out ==
			{1'b1, $past(mem_addr_in, 2), $past(d[6:0]), $past(c, 2)};
	endproperty
	a_rlc_mem: assert property (p_rlc_mem) else $error("mem rlc wrong");
endmodule
bind srs_unit srs_unit_sva u_sva(.*);

// ### dv/test_srs_unit.sv
// self-checking bench for srs_unit
// assumes srs_mem_model as the data memory
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %0t: got %h want %h", $time, g, e); end end
module test_srs_unit;
	import srs_pkg::*;
	logic        clk_in = 0, rst_n_in = 0, clk_en_in = 1, op_valid_in = 0;
	logic        acc_load_in = 0, flags_load_in = 0, c = 0;
	logic        op_ready_out, op_done_out, mem_rd_en_out;
	logic [7:0]  mem_addr_in = 0, acc_load_data_in = 0, mem_rd_data_in, a;
	logic [7:0]  mem_rd_addr_out, accumulator_out;
	logic [8:0]  e;
	srs_op_t     op_in = SRS_OP_NONE;
	srs_flags_t  flags_load_data_in = '0, flags_out;
	srs_mem_wr_t mem_wr_out;
	int          miscompares = 0, n_checks = 0;
	always #25 clk_in = ~clk_in;
	srs_unit u_dut(.*);
	srs_mem_model u_mem(.clk_in, .rd_en_in(mem_rd_en_out),
		.rd_addr_in(mem_rd_addr_out), .wr_in(mem_wr_out),
		.rd_data_out(mem_rd_data_in));
	function automatic logic [8:0] ex(srs_op_t o, logic [7:0] v, logic ci);
		case (o)
		SRS_OP_SHR_ACC, SRS_OP_SHR_MEM: ex = {v[0], 1'b0, v[7:1]};
		SRS_OP_RRC_ACC, SRS_OP_RRC_MEM: ex = {v[0], ci, v[7:1]};
		SRS_OP_SHL_ACC, SRS_OP_SHL_MEM: ex = {v, 1'b0};
		SRS_OP_RLC_ACC, SRS_OP_RLC_MEM: ex = {v, ci};
		default: ex = {ci, v[3:0], v[7:4]};
		endcase
	endfunction
	task t_mem;
		srs_op_t s[4] = '{SRS_OP_SHR_MEM, SRS_OP_RRC_MEM, SRS_OP_SHL_MEM,
			SRS_OP_RLC_MEM};
		for (int k = 0; k < 8; k++) begin
			op_in = s[k % 4];
			mem_addr_in = 8'(k * 29 + 3);
			e = ex(op_in, 8'(mem_addr_in * 37), c);
			op_valid_in = 1;
			#1;
			`CHK(op_ready_out, 1'b1)
			`CHK(mem_rd_en_out, 1'b1)
			`CHK(mem_rd_addr_out, mem_addr_in)
			@(negedge clk_in);
			op_valid_in = 0;
			`CHK(op_ready_out, 1'b0)
			@(negedge clk_in);
			c = e[8];
			`CHK(mem_wr_out, {1'b1, mem_addr_in, e[7:0]})
			`CHK(flags_out.carry_flag, c)
			@(negedge clk_in);
			`CHK(op_done_out, 1'b1)
		end
	endtask
	// back to back, valid held high across the whole run of ops
	task t_acc;
		srs_op_t s[5] = '{SRS_OP_SHR_ACC, SRS_OP_RRC_ACC, SRS_OP_SHL_ACC,
			SRS_OP_RLC_ACC, SRS_OP_SWAP_ACC};
		acc_load_in = 1;
		flags_load_in = 1;
		acc_load_data_in = 8'h97;
		flags_load_data_in = 4'hB;
		@(negedge clk_in);
		acc_load_in = 0;
		flags_load_in = 0;
		{c, a} = 9'h097;
		op_valid_in = 1;
		for (int k = 0; k < 10; k++) begin
			op_in = s[k % 5];
			e = ex(op_in, a, c);
			@(negedge clk_in);
			{c, a} = e;
			`CHK(accumulator_out, a)
			`CHK(flags_out, {1'b1, c, 2'b11})
		end
	endtask
	// clock enable low must freeze a pending accumulator op
	task t_freeze;
		clk_en_in = 0;
		op_in = SRS_OP_SHR_ACC;
		op_valid_in = 1;
		repeat (2) @(negedge clk_in);
		`CHK(accumulator_out, a)
		`CHK(flags_out, {1'b1, c, 2'b11})
		op_valid_in = 0;
		clk_en_in = 1;
		@(negedge clk_in);
		`CHK(accumulator_out, a)
		`CHK(op_done_out, 1'b0)
	endtask
	task conclude;
		if (miscompares == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk_in);
		rst_n_in = 1;
		t_mem;
		t_acc;
		t_freeze;
		conclude;
	end
	initial begin
		#20000;
		miscompares++;
		conclude;
	end
endmodule
